//--- pkg/srw_cfg.svh
`ifndef SRW_CFG_SVH
`define SRW_CFG_SVH

// ==========================================================================
// clock and timing
`define SRW_CLK_HZ          50000000
// power-up / manual reset stretch, selectable by the two reset-time bits
`define SRW_TRST0_US        50000
`define SRW_TRST1_US        200000
`define SRW_TRST2_US        400000
`define SRW_TRST3_US        800000
`define SRW_US_TO_CYC(us)   ((us) * (`SRW_CLK_HZ / 1000000))

// ==========================================================================
// register byte offsets
`define SRW_OFS_CTRL        8'h00
`define SRW_OFS_STATUS      8'h04
`define SRW_OFS_IRQ_STAT    8'h08
`define SRW_OFS_IRQ_MASK    8'h0c

// ==========================================================================
// control register fields
`define SRW_CTRL_SEL_LO     0
`define SRW_CTRL_SEL_HI     1
`define SRW_CTRL_LOCK_LO    2
`define SRW_CTRL_LOCK_HI    3
`define SRW_CTRL_RST        4'h0

// status register fields
`define SRW_ST_MAIN_RST     0
`define SRW_ST_AUX2_FAIL    1
`define SRW_ST_AUX3_FAIL    2
`define SRW_ST_WP           3
`define SRW_ST_MANUAL       4

// interrupt event bits
`define SRW_EV_RST_ON       0
`define SRW_EV_RST_OFF      1
`define SRW_EV_AUX2_LOW     2
`define SRW_EV_AUX3_LOW     3
`define SRW_EV_WR_REFUSED   4
`define SRW_EV_RST          5'h00

`endif

//--- pkg/srw_pkg.sv
package srw_pkg;

    // reset sequencer states
    typedef enum logic [1:0] {
        SRW_HOLD,
        SRW_STRETCH,
        SRW_RUN
    } srw_state_e;

    typedef logic [31:0] srw_count_t;
    typedef logic [1:0]  srw_sel_t;
    typedef logic [4:0]  srw_event_t;

endpackage : srw_pkg

//--- hdl/srw_sync.sv
`timescale 1ns/1ps

// ==========================================================================
// two-flop synchroniser, one per bit
module srw_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_q;

    // resets to zero, so each bit reads low only until two clocks after reset; a floating input is then passed through
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    meta_q[gi]  <= 1'b0;
                    syncOut[gi] <= 1'b0;
                end else begin
                    meta_q[gi]  <= asyncIn[gi];
                    syncOut[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

endmodule : srw_sync

//--- hdl/srw_supervisor.sv
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "srw_cfg.svh"

// Behaviour
// - aux2 fail output high while aux2 input above its trip, else low.
// - aux2 fail output has no power-up stretch; follows its comparator.
// - aux3 fail output high while aux3 input above its trip, else low.
// - aux3 fail output has no delay; changes with its comparator.
// - main reset output high whenever main supply is below its trip.
// - main reset high at power-up for the selected reset duration.
// - reset duration chosen by the two reset-time bits of control register.
// - manual reset input high starts a reset cycle.
// - main reset stays high for selected duration after manual reset falls.
// - nonvolatile writes refused while write-protect is high.
// - all writes refused when write-protect high and lock bits nonzero.
// - write-protect input left idle reads low, protection off; the synchroniser only forces it low during reset and for two clocks after.
module srw_supervisor
    import srw_pkg::*;
#(
    parameter int unsigned RST_CYC0 = `SRW_US_TO_CYC(`SRW_TRST0_US),
    parameter int unsigned RST_CYC1 = `SRW_US_TO_CYC(`SRW_TRST1_US),
    parameter int unsigned RST_CYC2 = `SRW_US_TO_CYC(`SRW_TRST2_US),
    parameter int unsigned RST_CYC3 = `SRW_US_TO_CYC(`SRW_TRST3_US)
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // comparator results and pins
    input  wire logic        mainSupplyLow,
    input  wire logic        aux2_monitor_input,
    input  wire logic        aux3_monitor_input,
    input  wire logic        manual_reset_input,
    input  wire logic        writeProtectIn,
    // write requests from the serial front end
    input  wire logic        nvWriteReq,
    input  wire logic        volWriteReq,
    output logic             nvWriteGo,
    output logic             volWriteGo,
    // outputs
    output logic             mainResetOut,
    output logic             aux2_fail_output,
    output logic             aux3_fail_output,
    output logic             irqOut
);

    // ======================================================================
    // input synchronisation
    logic [4:0] syncBits;
    logic       supplyLowS;
    logic       aux2S;
    logic       aux3S;
    logic       manualS;
    logic       wpS;

    // all asynchronous levels pass two flops before use
    srw_sync #(.WIDTH(5)) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .asyncIn ({writeProtectIn, manual_reset_input, aux3_monitor_input,
                   aux2_monitor_input, mainSupplyLow}),
        .syncOut (syncBits)
    );

    assign supplyLowS = syncBits[0];
    assign aux2S      = syncBits[1];
    assign aux3S      = syncBits[2];
    assign manualS    = syncBits[3];
    assign wpS        = syncBits[4];

    // ======================================================================
    // register state
    logic [3:0]  ctrl_q;
    srw_event_t  irqStat_q;
    srw_event_t  irqStat_d;
    srw_event_t  irqMask_q;
    srw_event_t  evSet;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic        busReq;
    logic        busWr;
    srw_sel_t    selNow;
    logic [1:0]  lockBits;

    assign busReq   = wb_cyc_i && wb_stb_i && !ack_q;
    assign busWr    = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0]; // acked edge
    assign selNow   = srw_sel_t'({ctrl_q[`SRW_CTRL_SEL_HI], ctrl_q[`SRW_CTRL_SEL_LO]});
    assign lockBits = {ctrl_q[`SRW_CTRL_LOCK_HI], ctrl_q[`SRW_CTRL_LOCK_LO]};

    // ======================================================================
    // reset sequencer
    srw_state_e  state_q;
    srw_state_e  state_d;
    srw_count_t  cnt_q;
    srw_count_t  cnt_d;
    srw_count_t  durCyc;
    srw_sel_t    selLatch_q;
    logic        cause;
    logic        mainRst_q;

    // either supply low or manual reset holds the sequencer
    assign cause = supplyLowS || manualS;

    // duration picked from the reset-time bits
    always_comb begin
        case (selNow)
            2'h0:    durCyc = srw_count_t'(RST_CYC0);
            2'h1:    durCyc = srw_count_t'(RST_CYC1);
            2'h2:    durCyc = srw_count_t'(RST_CYC2);
            default: durCyc = srw_count_t'(RST_CYC3);
        endcase
    end

    // next state; a cause during the stretch drops back to hold
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            SRW_HOLD: begin
                if (!cause) begin
                    state_d = SRW_STRETCH;
                    cnt_d   = durCyc - 32'h0000_0001;
                end
            end
            SRW_STRETCH: begin
                if (cause) begin
                    state_d = SRW_HOLD;
                end else if (cnt_q == 32'h0000_0000) begin
                    state_d = SRW_RUN;
                end else begin
                    cnt_d = cnt_q - 32'h0000_0001;
                end
            end
            default: begin
                if (cause) begin
                    state_d = SRW_HOLD;
                end
            end
        endcase
    end

    // power-up enters the stretch with the default selection; reset out comes
    // from the next state (no extra lag), selection held so a rewrite is harmless
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q    <= SRW_STRETCH;
            cnt_q      <= srw_count_t'(RST_CYC0) - 32'h0000_0001;
            selLatch_q <= 2'h0;
            mainRst_q  <= 1'b1;
        end else begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            mainRst_q <= (state_d != SRW_RUN);
            if (state_q == SRW_HOLD && !cause) begin
                selLatch_q <= selNow;
            end
        end
    end

    // ======================================================================
    // auxiliary fail outputs: straight copies, no stretch
    logic aux2_q;
    logic aux3_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aux2_q <= 1'b0;
            aux3_q <= 1'b0;
        end else begin
            aux2_q <= aux2S;
            aux3_q <= aux3S;
        end
    end

    // ======================================================================
    // write gate
    logic nvGo_q;
    logic volGo_q;
    logic nvBlock;
    logic volBlock;

    assign nvBlock  = wpS;
    assign volBlock = wpS && (lockBits != 2'h0);

    // one-cycle grant pulses; a blocked request is dropped, not queued
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            nvGo_q  <= 1'b0;
            volGo_q <= 1'b0;
        end else begin
            nvGo_q  <= nvWriteReq && !nvBlock && !volBlock;
            volGo_q <= volWriteReq && !volBlock;
        end
    end

    // ======================================================================
    // events and interrupt
    logic prevRst_q;
    logic prevAux2_q;
    logic prevAux3_q;
    logic irq_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prevRst_q  <= 1'b1;
            prevAux2_q <= 1'b0;
            prevAux3_q <= 1'b0;
        end else begin
            prevRst_q  <= mainRst_q;
            prevAux2_q <= aux2_q;
            prevAux3_q <= aux3_q;
        end
    end

    always_comb begin
        evSet = `SRW_EV_RST;
        evSet[`SRW_EV_RST_ON]     = mainRst_q && !prevRst_q;
        evSet[`SRW_EV_RST_OFF]    = !mainRst_q && prevRst_q;
        evSet[`SRW_EV_AUX2_LOW]   = !aux2_q && prevAux2_q;
        evSet[`SRW_EV_AUX3_LOW]   = !aux3_q && prevAux3_q;
        evSet[`SRW_EV_WR_REFUSED] = (nvWriteReq && (nvBlock || volBlock))
                                    || (volWriteReq && volBlock);
    end

    // write-one-to-clear; a new event beats a clear in the same cycle
    always_comb begin
        irqStat_d = irqStat_q;
        if (busWr && wb_adr_i == `SRW_OFS_IRQ_STAT) begin
            irqStat_d = irqStat_q & ~wb_dat_i[4:0];
        end
        irqStat_d = irqStat_d | evSet;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqStat_q <= `SRW_EV_RST;
            irq_q     <= 1'b0;
        end else begin
            irqStat_q <= irqStat_d;
            irq_q     <= |(irqStat_d & irqMask_q);
        end
    end

    // ======================================================================
    // wishbone slave: ack one cycle after request, unmapped reads zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q    <= `SRW_CTRL_RST;
            irqMask_q <= `SRW_EV_RST;
        end else if (busWr) begin
            if (wb_adr_i == `SRW_OFS_CTRL) begin
                ctrl_q <= wb_dat_i[3:0];
            end else if (wb_adr_i == `SRW_OFS_IRQ_MASK) begin
                irqMask_q <= wb_dat_i[4:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= busReq;
            rdat_q <= 32'h0000_0000;
            if (busReq && !wb_we_i) begin
                if (wb_adr_i == `SRW_OFS_CTRL) begin
                    rdat_q <= {28'h000_0000, ctrl_q};
                end else if (wb_adr_i == `SRW_OFS_STATUS) begin
                    rdat_q <= {27'h000_0000, manualS, wpS, aux3_q, aux2_q, mainRst_q};
                end else if (wb_adr_i == `SRW_OFS_IRQ_STAT) begin
                    rdat_q <= {27'h000_0000, irqStat_q};
                end else if (wb_adr_i == `SRW_OFS_IRQ_MASK) begin
                    rdat_q <= {27'h000_0000, irqMask_q};
                end
            end
        end
    end

    assign wb_ack_o         = ack_q;
    assign wb_dat_o         = rdat_q;
    assign mainResetOut     = mainRst_q;
    assign aux2_fail_output = aux2_q;
    assign aux3_fail_output = aux3_q;
    assign nvWriteGo        = nvGo_q;
    assign volWriteGo       = volGo_q;
    assign irqOut           = irq_q;

    // ======================================================================
    // checks
    srw_count_t stretchLen_q;
    srw_count_t expLen;
    // cycles spent in the stretch, for the duration check
    always_ff @(posedge clk) begin
        if (sys_rst || state_q == SRW_HOLD) begin
            stretchLen_q <= 32'h0000_0000;
        end else if (state_q == SRW_STRETCH) begin
            stretchLen_q <= stretchLen_q + 32'h0000_0001;
        end
    end
    always_comb begin
        case (selLatch_q)
            2'h0:    expLen = srw_count_t'(RST_CYC0);
            2'h1:    expLen = srw_count_t'(RST_CYC1);
            2'h2:    expLen = srw_count_t'(RST_CYC2);
            default: expLen = srw_count_t'(RST_CYC3);
        endcase
    end
    sequence s_aux2Hi;  aux2_monitor_input ##3 aux2_fail_output;   endsequence
    sequence s_aux3Lo;  !aux3_monitor_input ##3 !aux3_fail_output; endsequence
    property p_aux2High;
        @(posedge clk) disable iff (sys_rst) aux2_monitor_input |-> s_aux2Hi;
    endproperty
    a_aux2High: assert property (p_aux2High) else $error("aux2 fail not high");
    property p_aux2Low;
        @(posedge clk) disable iff (sys_rst) !aux2_monitor_input |-> ##3 !aux2_fail_output;
    endproperty
    a_aux2Low: assert property (p_aux2Low) else $error("aux2 fail stretched");
    property p_aux3High;
        @(posedge clk) disable iff (sys_rst) aux3_monitor_input |-> ##3 aux3_fail_output;
    endproperty
    a_aux3High: assert property (p_aux3High) else $error("aux3 fail not high");
    property p_aux3Low;
        @(posedge clk) disable iff (sys_rst) !aux3_monitor_input |-> s_aux3Lo;
    endproperty
    a_aux3Low: assert property (p_aux3Low) else $error("aux3 fail delayed");
    property p_supplyLow;
        @(posedge clk) disable iff (sys_rst) mainSupplyLow |-> ##3 mainResetOut;
    endproperty
    a_supplyLow: assert property (p_supplyLow) else $error("reset missing on low supply");
    property p_duration;
        @(posedge clk) disable iff (sys_rst) $fell(mainResetOut) |-> stretchLen_q == expLen;
    endproperty
    a_duration: assert property (p_duration) else $error("reset duration wrong");
    property p_manual;
        @(posedge clk) disable iff (sys_rst) manual_reset_input |-> ##3 mainResetOut;
    endproperty
    a_manual: assert property (p_manual) else $error("manual reset ignored");
    property p_nvBlock;
        @(posedge clk) disable iff (sys_rst)
            (nvWriteReq && wpS) |=> !nvWriteGo && irqStat_q[`SRW_EV_WR_REFUSED];
    endproperty
    a_nvBlock: assert property (p_nvBlock) else $error("nv write passed protect");
    property p_volBlock;
        @(posedge clk) disable iff (sys_rst)
            (volWriteReq && wpS && lockBits != 2'h0) |=> !volWriteGo;
    endproperty
    a_volBlock: assert property (p_volBlock) else $error("write passed lock");
    property p_restart;
        @(posedge clk) disable iff (sys_rst)
            (state_q == SRW_STRETCH && cause) |=> state_q == SRW_HOLD ##1 mainResetOut;
    endproperty
    a_restart: assert property (p_restart) else $error("stretch not restarted");
    property p_wpIdle;
        @(posedge clk) sys_rst |=> !wpS;
    endproperty
    a_wpIdle: assert property (p_wpIdle) else $error("protect on after reset");

endmodule : srw_supervisor

//--- hdl/srw_dummy_placeholder_removed.sv
`timescale 1ns/1ps
// ==========================================================================
// intentionally empty unit kept out of compile

//--- test/srw_host_model.sv
`timescale 1ns/1ps

// ==========================================================================
// host side: times each reset pulse and counts write grants
module srw_host_model (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        resetIn,
    input  wire logic        nvGo,
    input  wire logic        volGo,
    output logic      [15:0] pulseLen,
    output logic      [7:0]  grantCnt
);
    logic [15:0] runLen_q;

    // length of the last finished reset pulse; the host is held while high
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            runLen_q <= 16'h0000;
            pulseLen <= 16'h0000;
        end else if (resetIn) begin
            runLen_q <= runLen_q + 16'h0001;
        end else if (runLen_q != 16'h0000) begin
            pulseLen <= runLen_q;
            runLen_q <= 16'h0000;
        end
    end

    // a grant while the host is held in reset would be lost, so not counted
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            grantCnt <= 8'h00;
        end else if (!resetIn) begin
            grantCnt <= grantCnt + 8'(nvGo) + 8'(volGo);
        end
    end
endmodule : srw_host_model

//--- test/srw_supervisor_bench.sv
`timescale 1ns/1ps
`include "srw_cfg.svh"

module srw_supervisor_bench
    import srw_pkg::*;
;
    // short stretch counts keep the run brief
    localparam int unsigned C0 = 8;
    localparam int unsigned CYC [4] = '{8, 16, 24, 32};

    typedef struct packed {
        logic       wp;
        logic [1:0] lock;
        logic       nv;
        logic       vol;
    } srw_row_s;

    // ==========================================================================
    // nets
    logic        clk = 1'b0;
    logic        sysRst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic        supLow = 1'b0;
    logic        aux2In = 1'b0;
    logic        aux3In = 1'b0;
    logic        manIn = 1'b0;
    logic        wpIn = 1'b0;
    logic        nvReq = 1'b0;
    logic        volReq = 1'b0;
    logic [31:0] datO;
    logic        ack, nvGo, volGo, rstOut, aux2Fail, aux3Fail, irq;
    logic [15:0] pulseLen;
    logic [7:0]  grantCnt;
    logic [31:0] rd;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          tick = 0;
    int          nGrant = 0;
    srw_row_s    rows [6] = '{'{0, 0, 1, 1}, '{1, 0, 0, 1}, '{1, 1, 0, 0},
                              '{1, 2, 0, 0}, '{1, 3, 0, 0}, '{0, 3, 1, 1}};

    srw_supervisor #(.RST_CYC0(8), .RST_CYC1(16), .RST_CYC2(24), .RST_CYC3(32)) i_srw_supervisor (
        .clk(clk), .sys_rst(sysRst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack),
        .mainSupplyLow(supLow), .aux2_monitor_input(aux2In), .aux3_monitor_input(aux3In),
        .manual_reset_input(manIn), .writeProtectIn(wpIn), .nvWriteReq(nvReq),
        .volWriteReq(volReq), .nvWriteGo(nvGo), .volWriteGo(volGo), .mainResetOut(rstOut),
        .aux2_fail_output(aux2Fail), .aux3_fail_output(aux3Fail), .irqOut(irq));

    srw_host_model i_srw_host_model (
        .clk(clk), .sys_rst(sysRst), .resetIn(rstOut), .nvGo(nvGo), .volGo(volGo),
        .pulseLen(pulseLen), .grantCnt(grantCnt));

    // clock and hang guard; ceiling is over twenty times the expected run
    always #10 clk = ~clk;
    always @(posedge clk) begin
        tick++;
        if (tick == 10000) begin
            n_mismatch++;
            stop_test();
        end
    end

    // ==========================================================================
    // tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // pulse lengths are judged within a small window of edges
    task automatic chkIn(input string nm, input int lo, input int hi, input logic [15:0] g);
        samples_checked++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            n_mismatch++;
            $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : chkIn

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        r = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task automatic manual(input int hold);
        @(posedge clk);
        manIn <= 1'b1;
        repeat (hold) @(posedge clk);
        manIn <= 1'b0;
    endtask : manual

    task automatic waitFall(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rstOut !== 1'b0 && n < 2000);
    endtask : waitFall

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    // ==========================================================================
    // main sequence
    initial begin : main
        int n;
        repeat (7) @(posedge clk);
        #1 chk("reset held in sys_rst", 1, rstOut);
        @(posedge clk);
        sysRst <= 1'b0;
        waitFall(n);
        repeat (2) @(posedge clk);
        chkIn("power-up pulse", C0 - 1, C0 + 2, pulseLen);
        wb(1'b0, `SRW_OFS_CTRL, 32'h0, rd);
        chk("ctrl reset", 32'h0, rd);
        wb(1'b0, `SRW_OFS_IRQ_MASK, 32'h0, rd);
        chk("mask reset", 32'h0, rd);
        $display("test reset done");
        // write gate table
        foreach (rows[i]) begin
            wb(1'b1, `SRW_OFS_CTRL, 32'(rows[i].lock) << `SRW_CTRL_LOCK_LO, rd);
            wpIn <= rows[i].wp;
            repeat (4) @(posedge clk);
            nvReq  <= 1'b1;
            volReq <= 1'b1;
            @(posedge clk);
            nvReq  <= 1'b0;
            volReq <= 1'b0;
            #1 chk("nv grant", rows[i].nv, nvGo);
            chk("vol grant", rows[i].vol, volGo);
            nGrant += rows[i].nv + rows[i].vol;
            wb(1'b0, `SRW_OFS_STATUS, 32'h0, rd);
            chk("wp status", rows[i].wp, rd[`SRW_ST_WP]);
        end
        wpIn <= 1'b0;
        repeat (2) @(posedge clk);
        chk("grants at host", 8'(nGrant), grantCnt);
        $display("test write gate done");
        // sticky events, mask and write-one clear
        wb(1'b0, `SRW_OFS_IRQ_STAT, 32'h0, rd);
        chk("events after gate", 32'h12, rd);
        chk("irq masked", 0, irq);
        wb(1'b1, `SRW_OFS_IRQ_MASK, 32'h10, rd);
        repeat (2) @(posedge clk);
        #1 chk("irq unmasked", 1, irq);
        wb(1'b1, `SRW_OFS_IRQ_STAT, 32'h10, rd);
        repeat (2) @(posedge clk);
        #1 chk("irq cleared", 0, irq);
        wb(1'b1, `SRW_OFS_IRQ_STAT, 32'h1f, rd);
        wb(1'b0, 8'h20, 32'h0, rd);
        chk("unmapped read", 32'h0, rd);
        $display("test interrupt done");
        // every stretch selection after a manual reset
        for (int s = 0; s < 4; s++) begin
            wb(1'b1, `SRW_OFS_CTRL, 32'(s), rd);
            manual(10);
            #1 chk("manual reset high", 1, rstOut);
            waitFall(n);
            chkIn("manual stretch", CYC[s] + 2, CYC[s] + 4, 16'(n));
        end
        // a second cause inside the stretch starts the count again
        wb(1'b1, `SRW_OFS_CTRL, 32'h0, rd);
        manual(4);
        repeat (5) @(posedge clk);
        manual(4);
        waitFall(n);
        chkIn("restarted stretch", C0 + 2, C0 + 4, 16'(n));
        @(posedge clk);
        supLow <= 1'b1;
        repeat (30) @(posedge clk);
        #1 chk("supply low reset", 1, rstOut);
        @(posedge clk);
        supLow <= 1'b0;
        waitFall(n);
        chkIn("supply stretch", C0 + 2, C0 + 4, 16'(n));
        $display("test reset causes done");
        // fail outputs follow their inputs with no stretch
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            aux2In <= (i != 1);
            aux3In <= (i == 1);
            repeat (4) @(posedge clk);
            #1 chk("aux2 fail", (i != 1), aux2Fail);
            chk("aux3 fail", (i == 1), aux3Fail);
            chk("reset unaffected", 0, rstOut);
        end
        wb(1'b0, `SRW_OFS_IRQ_STAT, 32'h0, rd);
        chk("events after causes", 32'h0f, rd);
        wb(1'b1, `SRW_OFS_IRQ_MASK, 32'h0f, rd);
        repeat (2) @(posedge clk);
        #1 chk("irq from aux", 1, irq);
        $display("test fail outputs done");
        stop_test();
    end
endmodule : srw_supervisor_bench
